// file: src/spsb_shared_poll.sv
// Sensor-side function pulse decoder and slot logic for a shared SENT line
`timescale 1ns/10ps
module spsb_shared_poll (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic line_in,
	input wire logic line_collision_in,
	input wire logic cfg_addressed_in,
	input wire logic [spsb_pkg::MSG_W-1:0] cfg_outmsg_in,
	input wire logic [spsb_pkg::DIV_W-1:0] cfg_tick_div_in,
	input wire logic [spsb_pkg::SLOT_W-1:0] cfg_sensor_id_in,
	input wire logic [spsb_pkg::SLOT_W-1:0] cfg_max_slot_in,
	input wire logic cfg_slot_marking_in,
	input wire logic cfg_slot_sync_in,
	input wire logic cfg_por_offline_in,
	input wire logic cfg_idle_sync_in,
	input wire logic cfg_zero_sample_in,
	input wire logic cfg_no_sample_in,
	input wire logic cfg_sample_adr_in,
	input wire logic cfg_diag_adr_in,
	input wire logic cfg_diag_enable_in,
	output logic frame_req_out,
	output logic frame_held_out,
	output logic sample_hold_out,
	output logic diag_start_out,
	output logic resync_pending_state_out,
	output logic [spsb_pkg::SLOT_W-1:0] slot_index_counter_out
);
	import spsb_pkg::*;

	// ****************************************************************
	// Line meter
	// ****************************************************************
	spsb_meter_if meter_bus();

	spsb_line_meter u_meter (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.line_in(line_in),
		.tick_div_in(cfg_tick_div_in),
		.m(meter_bus)
	);

	// ****************************************************************
	// State
	// ****************************************************************
	spsb_state_t state_reg, state_next;
	spsb_fn_t pend_fn_reg, pend_fn_next;
	logic [SLOT_W-1:0] slot_index_counter_reg, slot_index_counter_next;
	logic [SLOT_W-1:0] target_reg, target_next;
	logic [SLOT_W-1:0] inc_cnt_reg, inc_cnt_next;
	logic resync_pending_state_reg, resync_pending_state_next;
	logic collided_reg, collided_next;
	logic held_reg, held_next;
	logic respond_reg, respond_next;
	logic measure_reg, measure_next;
	logic fired_reg, fired_next;
	logic init_done_reg, init_done_next;
	logic [ELAP_W-2:0] elapsed_reg, elapsed_next;
	logic frame_req_reg, frame_req_next;
	logic frame_held_reg, frame_held_next;
	logic sample_reg, sample_next;
	logic diag_reg, diag_next;

	// ****************************************************************
	// Decoding
	// ****************************************************************
	wire addr_mode_w = cfg_addressed_in;
	wire long_w = !addr_mode_w && (cfg_outmsg_in == OUTMSG_LONG);
	wire in_inc_w = state_reg == ST_INC_WAIT;
	spsb_fn_t fn_w;
	assign fn_w = spsb_decode(meter_bus.low_width, long_w, addr_mode_w,
		in_inc_w);
	wire pulse_w = meter_bus.rose && (fn_w != FN_NONE);
	wire is_out_w = fn_w == FN_OUTPUT;
	wire is_smp_w = fn_w == FN_SAMPLE;
	wire is_diag_w = fn_w == FN_DIAG;
	wire adr_fn_w = is_out_w || (is_smp_w && cfg_sample_adr_in) ||
		(is_diag_w && cfg_diag_adr_in);
	wire online_w = !resync_pending_state_reg;
	wire sync_w = pulse_w && (fn_w == FN_SYNC);
	wire seq_addr_w = pulse_w && !addr_mode_w && adr_fn_w;
	wire addressed_shared_polling_addr_w = pulse_w && addr_mode_w && adr_fn_w;
	wire inc_w = pulse_w && (fn_w == FN_INC);
	wire smp_hold_w = pulse_w && is_smp_w && !cfg_no_sample_in;
	wire zero_hold_w = seq_addr_w && is_out_w && cfg_zero_sample_in &&
		(slot_index_counter_reg == 2'h0);
	wire diag_bcast_w = pulse_w && is_diag_w && !cfg_diag_adr_in &&
		cfg_diag_enable_in;
	wire seq_me_w = slot_index_counter_reg == cfg_sensor_id_in;
	wire idle_w = cfg_idle_sync_in && meter_bus.level &&
		(meter_bus.high_ticks > IDLE_TICKS);
	wire addr_end_w = in_inc_w && meter_bus.level &&
		(meter_bus.high_ticks >= ADDR_END_TICKS);
	wire addressed_shared_polling_me_w = inc_cnt_reg == cfg_sensor_id_in;
	wire [HIGH_W-1:0] need_w = (!addr_mode_w && cfg_slot_marking_in) ?
		spsb_mark_delay(cfg_sensor_id_in) : MIN_GAP_TICKS;
	wire [ELAP_W-1:0] extra_w = SYNC_TICKS * {9'h000, cfg_tick_div_in};
	wire [ELAP_W-1:0] spent_w = {1'b0, elapsed_reg} + extra_w;
	wire proc_ok_w = spent_w >= PROC_CYC;
	wire gap_ok_w = meter_bus.level && proc_ok_w &&
		(meter_bus.high_ticks >= need_w);
	wire in_gap_w = state_reg == ST_GAP;
	wire frame_fire_w = in_gap_w && !meter_bus.fell && !pulse_w &&
		respond_reg && !fired_reg && gap_ok_w;
	wire [SLOT_W-1:0] mark_id_w = spsb_mark_id(meter_bus.high_ticks);
	wire eval_w = in_gap_w && !pulse_w && meter_bus.fell && measure_reg;
	wire mismatch_w = eval_w && online_w && (mark_id_w != target_reg);
	wire reload_w = eval_w && !online_w && !collided_reg &&
		cfg_slot_sync_in;
	wire timeout_w = measure_reg && (meter_bus.high_ticks > MARK_TIMEOUT);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		pend_fn_next = pend_fn_reg;
		slot_index_counter_next = slot_index_counter_reg;
		target_next = target_reg;
		inc_cnt_next = inc_cnt_reg;
		resync_pending_state_next = resync_pending_state_reg;
		collided_next = collided_reg;
		held_next = held_reg;
		respond_next = respond_reg;
		measure_next = measure_reg;
		fired_next = fired_reg;
		init_done_next = 1'b1;
		elapsed_next = (&elapsed_reg) ? elapsed_reg :
			(ELAP_W-1)'(elapsed_reg + 16'h0001);
		frame_req_next = 1'b0;
		frame_held_next = frame_held_reg;
		sample_next = smp_hold_w || zero_hold_w;
		diag_next = diag_bcast_w;
		if (smp_hold_w || zero_hold_w) held_next = 1'b1;
		if (pulse_w && !inc_w) elapsed_next = 16'h0000;
		if (!init_done_reg) begin
			slot_index_counter_next = 2'h0;
			resync_pending_state_next = cfg_por_offline_in;
		end
		if (sync_w) begin
			slot_index_counter_next = 2'h0;
			resync_pending_state_next = 1'b0;
			collided_next = 1'b0;
			state_next = ST_IDLE;
		end else if (seq_addr_w) begin
			target_next = slot_index_counter_reg;
			slot_index_counter_next = spsb_wrap(slot_index_counter_reg,
				cfg_max_slot_in);
			respond_next = seq_me_w && online_w && !is_diag_w;
			if (is_diag_w && seq_me_w && cfg_diag_enable_in)
				diag_next = 1'b1;
			measure_next = cfg_slot_marking_in;
			fired_next = 1'b0;
			state_next = ST_GAP;
		end else if (addressed_shared_polling_addr_w) begin
			pend_fn_next = fn_w;
			inc_cnt_next = 2'h0;
			state_next = ST_INC_WAIT;
		end else if (inc_w) begin
			if (inc_cnt_reg != 2'h3)
				inc_cnt_next = SLOT_W'(inc_cnt_reg + 2'h1);
		end else if (pulse_w) begin
			state_next = ST_IDLE;
		end else begin
			case (state_reg)
				ST_INC_WAIT: begin
					if (addr_end_w) begin
						target_next = inc_cnt_reg;
						respond_next = addressed_shared_polling_me_w && (pend_fn_reg != FN_DIAG);
						if (addressed_shared_polling_me_w && pend_fn_reg == FN_DIAG &&
							cfg_diag_enable_in)
							diag_next = 1'b1;
						measure_next = 1'b0;
						fired_next = 1'b0;
						state_next = ST_GAP;
					end
				end
				ST_GAP: begin
					if (meter_bus.fell) begin
						state_next = ST_IDLE;
						if (mismatch_w) resync_pending_state_next = 1'b1;
						if (reload_w) begin
							slot_index_counter_next = spsb_wrap(mark_id_w,
								cfg_max_slot_in);
							resync_pending_state_next = 1'b0;
						end
					end else if (frame_fire_w) begin
						frame_req_next = 1'b1;
						frame_held_next = held_reg;
						held_next = 1'b0;
						fired_next = 1'b1;
						if (!measure_reg) state_next = ST_IDLE;
					end else if (!respond_reg && !measure_reg) begin
						state_next = ST_IDLE;
					end else if (timeout_w) begin
						state_next = ST_IDLE;
					end
				end
				default: state_next = ST_IDLE;
			endcase
		end
		if (idle_w) begin
			slot_index_counter_next = 2'h0;
			resync_pending_state_next = 1'b0;
			collided_next = 1'b0;
		end
		if (line_collision_in) begin
			resync_pending_state_next = 1'b1;
			collided_next = 1'b1;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			pend_fn_reg <= FN_NONE;
			slot_index_counter_reg <= 2'h0;
			target_reg <= 2'h0;
			inc_cnt_reg <= 2'h0;
			resync_pending_state_reg <= 1'b1;
			collided_reg <= 1'b0;
			held_reg <= 1'b0;
			respond_reg <= 1'b0;
			measure_reg <= 1'b0;
			fired_reg <= 1'b0;
			init_done_reg <= 1'b0;
			elapsed_reg <= 16'hffff;
			frame_req_reg <= 1'b0;
			frame_held_reg <= 1'b0;
			sample_reg <= 1'b0;
			diag_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pend_fn_reg <= pend_fn_next;
			slot_index_counter_reg <= slot_index_counter_next;
			target_reg <= target_next;
			inc_cnt_reg <= inc_cnt_next;
			resync_pending_state_reg <= resync_pending_state_next;
			collided_reg <= collided_next;
			held_reg <= held_next;
			respond_reg <= respond_next;
			measure_reg <= measure_next;
			fired_reg <= fired_next;
			init_done_reg <= init_done_next;
			elapsed_reg <= elapsed_next;
			frame_req_reg <= frame_req_next;
			frame_held_reg <= frame_held_next;
			sample_reg <= sample_next;
			diag_reg <= diag_next;
		end
	end

	assign frame_req_out = frame_req_reg;
	assign frame_held_out = frame_held_reg;
	assign sample_hold_out = sample_reg;
	assign diag_start_out = diag_reg;
	assign resync_pending_state_out = resync_pending_state_reg;
	assign slot_index_counter_out = slot_index_counter_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	chk_frame_online_only: assert property (
		frame_req_out |-> addr_mode_w || $past(online_w))
		else $error("frame requested while offline");
	chk_gap_min_ticks: assert property (
		frame_req_out |-> $past(meter_bus.high_ticks) >= MIN_GAP_TICKS)
		else $error("response gap shorter than minimum");
	chk_proc_time: assert property (
		frame_fire_w |-> ({1'b0, elapsed_reg} + extra_w) >= PROC_CYC)
		else $error("frame launched before processing time");
	chk_mark_gap_id: assert property (
		(frame_fire_w && !addr_mode_w && cfg_slot_marking_in) |->
		meter_bus.high_ticks >= spsb_mark_delay(cfg_sensor_id_in))
		else $error("slot marking gap too short");
	chk_addressed_shared_polling_end_gap: assert property (
		(frame_fire_w && addr_mode_w) |->
		meter_bus.high_ticks >= ADDR_END_TICKS)
		else $error("addressed reply before increment timeout");
	chk_sync_slot_zero: assert property (
		(sync_w && !idle_w && !line_collision_in) |=>
		slot_index_counter_out == 2'h0 && !resync_pending_state_out)
		else $error("sync pulse did not clear slot counter");
	chk_slot_wrap_zero: assert property (
		(seq_addr_w && slot_index_counter_reg >= cfg_max_slot_in) |=>
		slot_index_counter_out == 2'h0)
		else $error("slot counter did not wrap");
	chk_idle_resync: assert property (
		(idle_w && !line_collision_in) |=>
		slot_index_counter_out == 2'h0 && !resync_pending_state_out)
		else $error("idle resync missed");
	chk_no_sample_hold: assert property (
		(cfg_no_sample_in && !cfg_zero_sample_in) |=> !sample_hold_out)
		else $error("sample held with sampling disabled");
	chk_zero_slot_hold: assert property (
		(seq_addr_w && is_out_w && cfg_zero_sample_in &&
		slot_index_counter_reg == 2'h0) |=> sample_hold_out)
		else $error("zero slot sample missed");
	chk_diag_broadcast: assert property (
		(pulse_w && is_diag_w && !cfg_diag_adr_in && cfg_diag_enable_in)
		|=> diag_start_out ##1 !frame_req_out)
		else $error("broadcast diagnostics not started");
	chk_bad_pulse_ignored: assert property (
		(meter_bus.rose && fn_w == FN_NONE && state_reg == ST_IDLE &&
		!idle_w && !line_collision_in && init_done_reg) |=>
		$stable(slot_index_counter_out) && $stable(resync_pending_state_out))
		else $error("invalid pulse changed state");
	chk_power_up_online: assert property (
		(!init_done_reg && !cfg_por_offline_in && !line_collision_in) |=>
		!resync_pending_state_out && slot_index_counter_out == 2'h0)
		else $error("power-up online start missed");

	cov_seq_frame: cover property (frame_fire_w && !addr_mode_w);
	cov_addressed_shared_polling_frame: cover property (frame_fire_w && addr_mode_w);
	cov_slot_reload: cover property (reload_w);
	cov_held_frame: cover property (frame_fire_w && held_reg);
endmodule

// file: src/spsb_pkg.sv
// Constants, types and helpers for the shared SENT line polling logic
// Notes on behaviour
// - Out-of-sync sensor, not from collision, loads slot from measured marking id.
// - Power-up offline option keeps sensor offline until sync or resync.
// - Without power-up offline, start with slot counter 0 and online.
// - Idle resync clears slot counter when line stays high over 510 ticks.
// - Responding sensor keeps line high at least 7 ticks before frame.
// - Gap stretched so 70.4 us pass from pulse rise to sync end.
// - Output request sends a frame with held data if pending, else fresh.
// - Zero-slot sampling holds data on output request rise for slot 0.
// - Sampling disabled without zero-slot sampling never holds, returns current data.
// - Sample pulse makes every sampling sensor hold data at its rise.
// - Sample addressing 0 means broadcast, no answer; 1 also addresses a sensor.
// - Diagnostic addressing 0: broadcast, no frame, self-test unless disabled.
// - Diagnostic addressing 1: addressed sensor sends nothing, self-tests if enabled.
// - Synchronise pulse sets slot counter so next addressing targets slot 0.
// - Short-trigger windows: output 15-19, sample 31-39, diag 56-70, sync 93-115.
// - Long-trigger windows: output 9-81, sync 105-171, diag 216-264, no sample.
// - Addressed mode: zero to three increments follow; count equal to id responds.
// - Increment sequence ends after about 18 ticks high, stretched if needed.
// - Addressed windows: output 15-19, sample 31-39, diag 56-70, no sync.
// - Sequential slot counter advances per addressing pulse, wraps, skips broadcasts.
// - Slot marking gap is 7, 18, 36 or 62 ticks per identity.
// - Measured transmitter id unequal to slot counter sends sensor offline.
package spsb_pkg;

	localparam int MSG_W = 3;
	localparam int DIV_W = 8;
	localparam int SLOT_W = 2;
	localparam int WID_W = 9;
	localparam int HIGH_W = 10;
	localparam int ELAP_W = 17;

	localparam logic [MSG_W-1:0] OUTMSG_LONG = 3'h3;
	localparam logic [MSG_W-1:0] OUTMSG_SHORT = 3'h4;

	// Low pulse windows in ticks
	localparam logic [WID_W-1:0] S_OUT_MIN = 9'h00f;
	localparam logic [WID_W-1:0] S_OUT_MAX = 9'h013;
	localparam logic [WID_W-1:0] S_SMP_MIN = 9'h01f;
	localparam logic [WID_W-1:0] S_SMP_MAX = 9'h027;
	localparam logic [WID_W-1:0] S_DIAG_MIN = 9'h038;
	localparam logic [WID_W-1:0] S_DIAG_MAX = 9'h046;
	localparam logic [WID_W-1:0] S_SYNC_MIN = 9'h05d;
	localparam logic [WID_W-1:0] S_SYNC_MAX = 9'h073;
	localparam logic [WID_W-1:0] L_OUT_MIN = 9'h009;
	localparam logic [WID_W-1:0] L_OUT_MAX = 9'h051;
	localparam logic [WID_W-1:0] L_SYNC_MIN = 9'h069;
	localparam logic [WID_W-1:0] L_SYNC_MAX = 9'h0ab;
	localparam logic [WID_W-1:0] L_DIAG_MIN = 9'h0d8;
	localparam logic [WID_W-1:0] L_DIAG_MAX = 9'h108;
	localparam logic [WID_W-1:0] INC_MIN = 9'h003;
	localparam logic [WID_W-1:0] INC_MAX = 9'h008;

	// High times in ticks
	localparam logic [HIGH_W-1:0] MIN_GAP_TICKS = 10'h007;
	localparam logic [HIGH_W-1:0] ADDR_END_TICKS = 10'h012;
	localparam logic [HIGH_W-1:0] IDLE_TICKS = 10'h1fe;
	localparam logic [HIGH_W-1:0] MARK_D0 = 10'h007;
	localparam logic [HIGH_W-1:0] MARK_D1 = 10'h012;
	localparam logic [HIGH_W-1:0] MARK_D2 = 10'h024;
	localparam logic [HIGH_W-1:0] MARK_D3 = 10'h03e;
	localparam logic [HIGH_W-1:0] MARK_SPLIT1 = 10'h00d;
	localparam logic [HIGH_W-1:0] MARK_SPLIT2 = 10'h01b;
	localparam logic [HIGH_W-1:0] MARK_SPLIT3 = 10'h031;
	localparam logic [HIGH_W-1:0] MARK_TIMEOUT = 10'h050;

	// Processing time from pulse rise to end of sync, in core clocks
	localparam int CLK_PERIOD_NS = 40;
	localparam int PROC_TIME_NS = 70400;
	localparam logic [ELAP_W-1:0] PROC_CYC =
		ELAP_W'((PROC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [ELAP_W-1:0] SYNC_TICKS = 17'h00038;

	typedef enum logic [2:0] {
		FN_NONE, FN_OUTPUT, FN_SAMPLE, FN_DIAG, FN_SYNC, FN_INC
	} spsb_fn_t;

	typedef enum logic [1:0] {ST_IDLE, ST_INC_WAIT, ST_GAP} spsb_state_t;

	function automatic logic spsb_in_win(input logic [WID_W-1:0] w,
		input logic [WID_W-1:0] lo, input logic [WID_W-1:0] hi);
		return (w >= lo) && (w <= hi);
	endfunction

	function automatic spsb_fn_t spsb_decode(input logic [WID_W-1:0] w,
		input logic long_mode, input logic addressed, input logic inc_ok);
		spsb_fn_t f;
		f = FN_NONE;
		if (long_mode) begin
			if (spsb_in_win(w, L_OUT_MIN, L_OUT_MAX)) f = FN_OUTPUT;
			else if (spsb_in_win(w, L_SYNC_MIN, L_SYNC_MAX)) f = FN_SYNC;
			else if (spsb_in_win(w, L_DIAG_MIN, L_DIAG_MAX)) f = FN_DIAG;
		end else begin
			if (spsb_in_win(w, S_OUT_MIN, S_OUT_MAX)) f = FN_OUTPUT;
			else if (spsb_in_win(w, S_SMP_MIN, S_SMP_MAX)) f = FN_SAMPLE;
			else if (spsb_in_win(w, S_DIAG_MIN, S_DIAG_MAX)) f = FN_DIAG;
			else if (!addressed && spsb_in_win(w, S_SYNC_MIN, S_SYNC_MAX))
				f = FN_SYNC;
		end
		if (inc_ok && spsb_in_win(w, INC_MIN, INC_MAX)) f = FN_INC;
		return f;
	endfunction

	function automatic logic [HIGH_W-1:0] spsb_mark_delay(
		input logic [SLOT_W-1:0] id);
		case (id)
			2'h0: return MARK_D0;
			2'h1: return MARK_D1;
			2'h2: return MARK_D2;
			default: return MARK_D3;
		endcase
	endfunction

	function automatic logic [SLOT_W-1:0] spsb_mark_id(
		input logic [HIGH_W-1:0] t);
		if (t < MARK_SPLIT1) return 2'h0;
		if (t < MARK_SPLIT2) return 2'h1;
		if (t < MARK_SPLIT3) return 2'h2;
		return 2'h3;
	endfunction

	function automatic logic [SLOT_W-1:0] spsb_wrap(
		input logic [SLOT_W-1:0] s, input logic [SLOT_W-1:0] max_slot);
		return (s >= max_slot) ? 2'h0 : SLOT_W'(s + 2'h1);
	endfunction

endpackage

// file: src/spsb_meter_if.sv
// Carrier between the line meter and the polling logic
`timescale 1ns/10ps
interface spsb_meter_if;
	logic fell;
	logic rose;
	logic level;
	logic [spsb_pkg::WID_W-1:0] low_width;
	logic [spsb_pkg::HIGH_W-1:0] high_ticks;
	modport meter(output fell, rose, level, low_width, high_ticks);
	modport user(input fell, rose, level, low_width, high_ticks);
endinterface

// file: src/spsb_line_meter.sv
// Line edge detector and tick-based low and high time meter
`timescale 1ns/10ps
module spsb_line_meter (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic line_in,
	input wire logic [spsb_pkg::DIV_W-1:0] tick_div_in,
	spsb_meter_if.meter m
);
	import spsb_pkg::*;

	logic prev_reg;
	logic fell_reg;
	logic rose_reg;
	logic [DIV_W-1:0] tick_cnt_reg;
	logic [WID_W-1:0] low_cnt_reg;
	logic [WID_W-1:0] width_reg;
	logic [HIGH_W-1:0] high_reg;

	wire fell_w = prev_reg && !line_in;
	wire rose_w = !prev_reg && line_in;
	wire edge_w = fell_w || rose_w;
	wire [DIV_W-1:0] div_last_w = (tick_div_in == 8'h00) ? 8'h00 :
		DIV_W'(tick_div_in - 8'h01);
	wire tick_w = tick_cnt_reg >= div_last_w;
	wire low_sat_w = &low_cnt_reg;
	wire high_sat_w = &high_reg;

	// Tick phase restarts at every edge so widths count from the edge
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_reg <= 1'b1;
			fell_reg <= 1'b0;
			rose_reg <= 1'b0;
			tick_cnt_reg <= 8'h00;
			low_cnt_reg <= 9'h000;
			width_reg <= 9'h000;
			high_reg <= 10'h000;
		end else begin
			prev_reg <= line_in;
			fell_reg <= fell_w;
			rose_reg <= rose_w;
			tick_cnt_reg <= (edge_w || tick_w) ? 8'h00 :
				DIV_W'(tick_cnt_reg + 8'h01);
			// Fall is seen one clock late, so the count starts at one
			if (fell_w) low_cnt_reg <= 9'h001;
			else if (tick_w && !prev_reg && !low_sat_w)
				low_cnt_reg <= WID_W'(low_cnt_reg + 9'h001);
			if (rose_w) width_reg <= low_cnt_reg;
			if (rose_w) high_reg <= 10'h000;
			else if (tick_w && prev_reg && !high_sat_w)
				high_reg <= HIGH_W'(high_reg + 10'h001);
		end
	end

	assign m.fell = fell_reg;
	assign m.rose = rose_reg;
	assign m.level = prev_reg;
	assign m.low_width = width_reg;
	assign m.high_ticks = high_reg;
endmodule

// file: testbench/spsb_host_model.sv
// Host controller model driving timed low pulses on the shared line
`timescale 1ns/10ps
module spsb_host_model (
	input wire logic core_clk_in,
	output logic line_out
);
	// Line rests high through the pull-up
	initial line_out = 1'b1;

	// Low pulse of so many ticks, one clock per tick, then high time
	task automatic send_pulse(input int ticks, input int gap);
		@(posedge core_clk_in);
		line_out <= 1'b0;
		repeat (ticks) @(posedge core_clk_in);
		line_out <= 1'b1;
		repeat (gap) @(posedge core_clk_in);
	endtask
endmodule

// file: testbench/spsb_shared_poll_test.sv
// Self-checking bench for the shared line polling logic
`timescale 1ns/10ps
module spsb_shared_poll_test;
	import spsb_pkg::*;
	logic clk, rst, line, frame, held, smp, diag, offl, por_off, idle_sync;
	logic zero_smp, no_smp, smp_adr, diag_adr, diag_en, adr;
	logic [MSG_W-1:0] outmsg;
	logic [SLOT_W-1:0] max_slot, id, slot, es;
	int n_errors, num_checks, n_frame, n_smp, n_diag;

	spsb_host_model spsb_host_model_i (.core_clk_in(clk), .line_out(line));
	spsb_shared_poll spsb_shared_poll_i (.core_clk_in(clk), .rst_in(rst),
		.line_in(line), .line_collision_in(1'b0), .cfg_addressed_in(adr),
		.cfg_outmsg_in(outmsg), .cfg_tick_div_in(8'h01),
		.cfg_sensor_id_in(id), .cfg_max_slot_in(max_slot),
		.cfg_slot_marking_in(1'b0), .cfg_slot_sync_in(1'b0),
		.cfg_por_offline_in(por_off), .cfg_idle_sync_in(idle_sync),
		.cfg_zero_sample_in(zero_smp), .cfg_no_sample_in(no_smp),
		.cfg_sample_adr_in(smp_adr), .cfg_diag_adr_in(diag_adr),
		.cfg_diag_enable_in(diag_en), .frame_req_out(frame),
		.frame_held_out(held), .sample_hold_out(smp),
		.diag_start_out(diag), .resync_pending_state_out(offl),
		.slot_index_counter_out(slot));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Pulse counters on the outputs
	always @(posedge clk) begin
		if (frame === 1'b1) n_frame <= n_frame + 1;
		if (smp === 1'b1) n_smp <= n_smp + 1;
		if (diag === 1'b1) n_diag <= n_diag + 1;
	end

	function automatic logic [SLOT_W-1:0] nxt(input logic [SLOT_W-1:0] s);
		return (s >= max_slot) ? 2'h0 : SLOT_W'(s + 2'h1);
	endfunction

	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task automatic do_reset(input logic po);
		por_off <= po;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// One function pulse, then expected pulse counts and slot
	task automatic fn(input int w, input int f, input int s, input int d,
		input logic [SLOT_W-1:0] e);
		int f0, s0, d0;
		f0 = n_frame;
		s0 = n_smp;
		d0 = n_diag;
		spsb_host_model_i.send_pulse(w, 1800);
		check(slot === e && n_frame == f0 + f && n_smp == s0 + s &&
			n_diag == d0 + d, "function pulse outcome");
	endtask

	// Addressed poll: function pulse, k increments, then a long high
	task automatic afn(input int k, input int f);
		int f0;
		f0 = n_frame;
		spsb_host_model_i.send_pulse(17, 10);
		repeat (k) spsb_host_model_i.send_pulse(5, 10);
		repeat (1800) @(posedge clk);
		check(n_frame == f0 + f, "addressed reply");
	endtask

	task automatic test_done();
		if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		{rst, por_off, idle_sync, zero_smp, no_smp, smp_adr, diag_adr} = '0;
		adr = 1'b0;
		{n_errors, num_checks, n_frame, n_smp, n_diag} = '0;
		diag_en = 1'b1;
		outmsg = OUTMSG_SHORT;
		max_slot = 2'h2;
		id = 2'h0;
		void'($urandom(57));
		do_reset(1'b0);
		check(offl === 1'b0 && slot === 2'h0, "power-up state");
		fn(17, 1, 0, 0, 2'h1);
		check(held === 1'b0, "fresh data");
		fn(17, 0, 0, 0, 2'h2);
		fn(17, 0, 0, 0, 2'h0);
		fn(25, 0, 0, 0, 2'h0);
		fn(35, 0, 1, 0, 2'h0);
		fn(17, 1, 0, 0, 2'h1);
		check(held === 1'b1, "held data");
		fn(63, 0, 0, 1, 2'h1);
		fn(104, 0, 0, 0, 2'h0);
		diag_adr <= 1'b1;
		fn(63, 0, 0, 1, 2'h1);
		fn(63, 0, 0, 0, 2'h2);
		smp_adr <= 1'b1;
		fn(35, 0, 1, 0, 2'h0);
		zero_smp <= 1'b1;
		fn(17, 1, 1, 0, 2'h1);
		zero_smp <= 1'b0;
		no_smp <= 1'b1;
		fn(35, 0, 0, 0, 2'h2);
		{no_smp, smp_adr, diag_adr} <= '0;
		outmsg <= OUTMSG_LONG;
		fn(140, 0, 0, 0, 2'h0);
		fn(40, 1, 0, 0, 2'h1);
		fn(240, 0, 0, 1, 2'h1);
		fn(90, 0, 0, 0, 2'h1);
		outmsg <= OUTMSG_SHORT;
		fn(104, 0, 0, 0, 2'h0);
		es = 2'h0;
		repeat (12) begin
			id <= SLOT_W'($urandom % 3);
			@(posedge clk);
			fn(16 + $urandom % 3, int'(es == id), 0, 0, nxt(es));
			es = nxt(es);
		end
		do_reset(1'b1);
		check(offl === 1'b1, "stays offline");
		fn(104, 0, 0, 0, 2'h0);
		check(offl === 1'b0, "online after sync");
		id <= 2'h3;
		idle_sync <= 1'b1;
		fn(17, 0, 0, 0, 2'h0);
		adr <= 1'b1;
		afn(3, 1);
		afn(1, 0);
		test_done();
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		test_done();
	end
endmodule
